/* hdl/adc_diag_pkg.sv */
// Constants and carrier types of the converter diagnostic register bank.
// Assumes a 32-bit AXI4-Lite bus; register index times four is the byte address.
package adc_diag_pkg;
  localparam int ADDR_W = 8;
  localparam int IDX_W  = 6;
  // Register indices
  localparam logic [IDX_W-1:0] IDX_PATTERN_AB  = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_PATTERN_CD  = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_WORD_HIGH   = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_WORD_LOW    = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_HEALTH_TEMP = 6'h10;
  localparam logic [IDX_W-1:0] IDX_TEMP_HIGH   = 6'h11;
  localparam logic [IDX_W-1:0] IDX_DIAG_CTRL   = 6'h13;
  localparam logic [IDX_W-1:0] IDX_TEMP_CTRL   = 6'h14;
  localparam logic [IDX_W-1:0] IDX_DIAG_SEL    = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 6'h30;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 6'h31;
  // Field positions
  localparam int WORD_LOW_POS   = 4;
  localparam int REF_CHECK_POS  = 6;
  localparam int DC_EN_POS      = 5;
  localparam int STATS_EN_POS   = 4;
  localparam int LOW_SPEED_POS  = 0;
  localparam int TEMP_RD_POS    = 2;
  localparam int DC_LEVEL_POS   = 0;
  localparam int STATS_SEL_POS  = 4;
  localparam int HEALTH_B_POS   = 7;
  localparam int HEALTH_D_POS   = 6;
  localparam int HEALTH_A_POS   = 5;
  localparam int CLK_STAT_POS   = 4;
  localparam int TEMP_MID_POS   = 1;
  localparam int HEALTH_C_POS   = 0;
  localparam int TEMP_TOP_POS   = 4;
  localparam int IRQ_CLK_LOST   = 0;
  localparam int IRQ_REF_FAULT  = 1;
  // Values
  localparam logic [3:0] PATTERN_CUSTOM = 4'h5;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic [3:0] ref_health;  // Channels D, C, B, A from bit 3 down
    logic       clk_present;
    logic [8:0] temperature;
  } sense_s;

  typedef struct packed {
    logic       ref_check_enable;
    logic       dc_inject_enable;
    logic       statistics_enable;
    logic [1:0] low_speed_sel;
    logic       temperature_readout_enable;
  } diag_ctrl_s;
endpackage

/* hdl/adc_diag_config_regs.sv */
// Diagnostic and test-word register bank of a four-channel 12-bit converter.
// Assumes an AXI4-Lite master on aclk; sense inputs arrive from the analog side
// asynchronously and the temperature word changes slowly relative to aclk.
`timescale 1ns/100ps
module adc_diag_config_regs (
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  input  wire logic [adc_diag_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]                         s_axi_awprot,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [adc_diag_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]                         s_axi_arprot,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  input  wire adc_diag_pkg::sense_s               sense_in,
  output adc_diag_pkg::diag_ctrl_s                diag_ctrl,
  output logic [2:0]                              dc_inject_level,
  output logic [1:0]                              statistics_channel_select,
  output logic [11:0]                             test_word,
  output logic [3:0]                              custom_pattern_active,
  output logic                                    irq
);

  function automatic logic [adc_diag_pkg::IDX_W-1:0] reg_index(
    input logic [adc_diag_pkg::ADDR_W-1:0] addr
  );
    reg_index = addr[adc_diag_pkg::ADDR_W-1:2];
  endfunction

  function automatic logic mapped(input logic [adc_diag_pkg::IDX_W-1:0] idx);
    case (idx)
      adc_diag_pkg::IDX_PATTERN_AB, adc_diag_pkg::IDX_PATTERN_CD,
      adc_diag_pkg::IDX_WORD_HIGH, adc_diag_pkg::IDX_WORD_LOW,
      adc_diag_pkg::IDX_HEALTH_TEMP, adc_diag_pkg::IDX_TEMP_HIGH,
      adc_diag_pkg::IDX_DIAG_CTRL, adc_diag_pkg::IDX_TEMP_CTRL,
      adc_diag_pkg::IDX_DIAG_SEL, adc_diag_pkg::IDX_IRQ_STATUS,
      adc_diag_pkg::IDX_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  adc_diag_pkg::sense_s sense_meta_r;
  adc_diag_pkg::sense_s sense_r;
  adc_diag_pkg::sense_s sense_prev_r;
  logic [7:0]  pattern_ab_r;
  logic [7:0]  pattern_cd_r;
  logic [1:0]  irq_status_r;
  logic [1:0]  irq_mask_r;
  logic [1:0]  irq_event;
  logic        aw_full_r;
  logic        w_full_r;
  logic [adc_diag_pkg::IDX_W-1:0] wr_idx_r;
  logic [7:0]  wr_data_r;
  logic        wr_strb_r;
  logic        wr_fire;
  logic        wr_en;
  logic [7:0]  rd_byte;
  logic [adc_diag_pkg::IDX_W-1:0] rd_idx;

  // Two-stage synchroniser for asynchronous sense inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_meta_r <= '0;
      sense_r      <= '0;
      sense_prev_r <= '0;
    end else begin
      sense_meta_r <= sense_in;
      sense_r      <= sense_meta_r;
      sense_prev_r <= sense_r;
    end
  end

  // Write address and data may arrive in either order
  assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_en   = wr_fire && wr_strb_r && mapped(wr_idx_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r     <= 1'b0;
      w_full_r      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= adc_diag_pkg::RESP_OKAY;
      wr_idx_r      <= '0;
      wr_data_r     <= '0;
      wr_strb_r     <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r     <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_idx_r      <= reg_index(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r     <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data_r    <= s_axi_wdata[7:0];
        wr_strb_r    <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_idx_r) ? adc_diag_pkg::RESP_OKAY
                                         : adc_diag_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_full_r     <= 1'b0;
        w_full_r      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Configuration registers; reserved bits are never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_word    <= '0;
      pattern_ab_r <= adc_diag_pkg::REG_RESET;
      pattern_cd_r <= adc_diag_pkg::REG_RESET;
      diag_ctrl    <= '0;
    end else if (wr_en) begin
      case (wr_idx_r)
        adc_diag_pkg::IDX_WORD_HIGH: test_word[11:4] <= wr_data_r;
        adc_diag_pkg::IDX_WORD_LOW:
          test_word[3:0] <= wr_data_r[adc_diag_pkg::WORD_LOW_POS +: 4];
        adc_diag_pkg::IDX_PATTERN_AB: pattern_ab_r <= wr_data_r;
        adc_diag_pkg::IDX_PATTERN_CD: pattern_cd_r <= wr_data_r;
        adc_diag_pkg::IDX_DIAG_CTRL: begin
          diag_ctrl.ref_check_enable  <= wr_data_r[adc_diag_pkg::REF_CHECK_POS];
          diag_ctrl.dc_inject_enable  <= wr_data_r[adc_diag_pkg::DC_EN_POS];
          diag_ctrl.statistics_enable <= wr_data_r[adc_diag_pkg::STATS_EN_POS];
          diag_ctrl.low_speed_sel     <= wr_data_r[adc_diag_pkg::LOW_SPEED_POS +: 2];
        end
        adc_diag_pkg::IDX_TEMP_CTRL:
          diag_ctrl.temperature_readout_enable <= wr_data_r[adc_diag_pkg::TEMP_RD_POS];
        default: ;
      endcase
    end
  end

  // Level and channel select are taken only while their enable is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dc_inject_level           <= '0;
      statistics_channel_select <= '0;
    end else if (wr_en && wr_idx_r == adc_diag_pkg::IDX_DIAG_SEL) begin
      if (diag_ctrl.dc_inject_enable)
        dc_inject_level <= wr_data_r[adc_diag_pkg::DC_LEVEL_POS +: 3];
      if (diag_ctrl.statistics_enable)
        statistics_channel_select <= wr_data_r[adc_diag_pkg::STATS_SEL_POS +: 2];
    end
  end

  // Channel order of the flags is D, C, B, A from bit 3 down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      custom_pattern_active <= '0;
    end else begin
      custom_pattern_active[0] <= pattern_ab_r[7:4] == adc_diag_pkg::PATTERN_CUSTOM;
      custom_pattern_active[1] <= pattern_ab_r[3:0] == adc_diag_pkg::PATTERN_CUSTOM;
      custom_pattern_active[2] <= pattern_cd_r[7:4] == adc_diag_pkg::PATTERN_CUSTOM;
      custom_pattern_active[3] <= pattern_cd_r[3:0] == adc_diag_pkg::PATTERN_CUSTOM;
    end
  end

  // Events: clock goes missing, or a checked reference health bit drops
  assign irq_event[adc_diag_pkg::IRQ_CLK_LOST]  = sense_prev_r.clk_present
                                                  && !sense_r.clk_present;
  assign irq_event[adc_diag_pkg::IRQ_REF_FAULT] = diag_ctrl.ref_check_enable
                                                  && |(sense_prev_r.ref_health
                                                       & ~sense_r.ref_health);

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= '0;
      irq_mask_r   <= '0;
      irq          <= 1'b0;
    end else begin
      if (wr_en && wr_idx_r == adc_diag_pkg::IDX_IRQ_STATUS)
        irq_status_r <= (irq_status_r & ~wr_data_r[1:0]) | irq_event;
      else
        irq_status_r <= irq_status_r | irq_event;
      if (wr_en && wr_idx_r == adc_diag_pkg::IDX_IRQ_MASK)
        irq_mask_r <= wr_data_r[1:0];
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  // Read-back multiplexer
  assign rd_idx = reg_index(s_axi_araddr);

  always_comb begin
    rd_byte = '0;
    case (rd_idx)
      adc_diag_pkg::IDX_WORD_HIGH: rd_byte = test_word[11:4];
      adc_diag_pkg::IDX_WORD_LOW:
        rd_byte[adc_diag_pkg::WORD_LOW_POS +: 4] = test_word[3:0];
      adc_diag_pkg::IDX_PATTERN_AB: rd_byte = pattern_ab_r;
      adc_diag_pkg::IDX_PATTERN_CD: rd_byte = pattern_cd_r;
      adc_diag_pkg::IDX_HEALTH_TEMP: begin
        rd_byte[adc_diag_pkg::CLK_STAT_POS] = !sense_r.clk_present;
        if (diag_ctrl.temperature_readout_enable) begin
          rd_byte[adc_diag_pkg::HEALTH_B_POS] = sense_r.temperature[2];
          rd_byte[adc_diag_pkg::HEALTH_D_POS] = sense_r.temperature[1];
          rd_byte[adc_diag_pkg::HEALTH_A_POS] = sense_r.temperature[0];
          rd_byte[adc_diag_pkg::HEALTH_C_POS] = sense_r.temperature[3];
          rd_byte[adc_diag_pkg::TEMP_MID_POS +: 3] = sense_r.temperature[6:4];
        end else if (diag_ctrl.ref_check_enable) begin
          rd_byte[adc_diag_pkg::HEALTH_B_POS] = sense_r.ref_health[1];
          rd_byte[adc_diag_pkg::HEALTH_D_POS] = sense_r.ref_health[3];
          rd_byte[adc_diag_pkg::HEALTH_A_POS] = sense_r.ref_health[0];
          rd_byte[adc_diag_pkg::HEALTH_C_POS] = sense_r.ref_health[2];
        end
      end
      adc_diag_pkg::IDX_TEMP_HIGH:
        if (diag_ctrl.temperature_readout_enable)
          rd_byte[adc_diag_pkg::TEMP_TOP_POS +: 2] = sense_r.temperature[8:7];
      adc_diag_pkg::IDX_DIAG_CTRL: begin
        rd_byte[adc_diag_pkg::REF_CHECK_POS] = diag_ctrl.ref_check_enable;
        rd_byte[adc_diag_pkg::DC_EN_POS]     = diag_ctrl.dc_inject_enable;
        rd_byte[adc_diag_pkg::STATS_EN_POS]  = diag_ctrl.statistics_enable;
        rd_byte[adc_diag_pkg::LOW_SPEED_POS +: 2] = diag_ctrl.low_speed_sel;
      end
      adc_diag_pkg::IDX_TEMP_CTRL:
        rd_byte[adc_diag_pkg::TEMP_RD_POS] = diag_ctrl.temperature_readout_enable;
      adc_diag_pkg::IDX_DIAG_SEL: begin
        rd_byte[adc_diag_pkg::DC_LEVEL_POS +: 3]  = dc_inject_level;
        rd_byte[adc_diag_pkg::STATS_SEL_POS +: 2] = statistics_channel_select;
      end
      adc_diag_pkg::IDX_IRQ_STATUS: rd_byte[1:0] = irq_status_r;
      adc_diag_pkg::IDX_IRQ_MASK:   rd_byte[1:0] = irq_mask_r;
      default: rd_byte = '0;
    endcase
  end

  // Read channel: address taken, data one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= adc_diag_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= mapped(rd_idx) ? adc_diag_pkg::RESP_OKAY
                                      : adc_diag_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

/* test/adc_diag_config_regs_assertions.sv */
// Concurrent checks of the diagnostic register bank, bound to its top module.
// Assumes one aclk domain with a synchronous active-low aresetn.
`timescale 1ns/100ps
module adc_diag_config_regs_assertions (
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic [7:0]               s_axi_araddr,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire adc_diag_pkg::sense_s     sense_in,
  input wire adc_diag_pkg::diag_ctrl_s diag_ctrl,
  input wire logic [2:0]               dc_inject_level,
  input wire logic [1:0]               statistics_channel_select
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Read-back of the shared health and temperature registers
  function automatic logic [31:0] exp_rd(logic [7:0] a, adc_diag_pkg::sense_s s,
                                         adc_diag_pkg::diag_ctrl_s c);
    logic [8:0] t;
    logic [3:0] h;
    t = s.temperature;
    h = s.ref_health;
    if (a[7:2] == adc_diag_pkg::IDX_TEMP_HIGH) return c.temperature_readout_enable ?
      {26'h0, t[8:7], 4'h0} : 32'h0;
    if (c.temperature_readout_enable) return {24'h0, t[2:0], !s.clk_present, t[6:4], t[3]};
    if (c.ref_check_enable) return {24'h0, h[1], h[3], h[0], !s.clk_present, 3'h0, h[2]};
    return {27'h0, !s.clk_present, 4'h0};
  endfunction

  // Sense inputs quiet long enough to have crossed the synchronisers
  sequence s_quiet;
    (aresetn && $stable(sense_in))[*3];
  endsequence
  sequence s_sense_read;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:2] == adc_diag_pkg::IDX_HEALTH_TEMP ||
      s_axi_araddr[7:2] == adc_diag_pkg::IDX_TEMP_HIGH);
  endsequence

  a_sense_readback: assert property (s_quiet ##0 s_sense_read |=>
    s_axi_rdata == exp_rd($past(s_axi_araddr), $past(sense_in), $past(diag_ctrl)))
    else $error("sense read-back differs");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid && !s_axi_awready)
    else $error("write response not two edges after the take");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not after one edge");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_dc_level_gated: assert property (!diag_ctrl.dc_inject_enable |=> $stable(dc_inject_level))
    else $error("injection level changed while disabled");
  a_stats_sel_gated: assert property (!diag_ctrl.statistics_enable |=>
    $stable(statistics_channel_select)) else $error("channel select changed while disabled");
endmodule
bind adc_diag_config_regs adc_diag_config_regs_assertions i_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sense_in,
  .diag_ctrl, .dc_inject_level, .statistics_channel_select);

/* test/adc_diag_config_regs_tb_top.sv */
// Self-checking bench for the diagnostic register bank over AXI4-Lite.
// Assumes a 100 MHz aclk and a synchronous active-low aresetn.
`timescale 1ns/100ps
module adc_diag_config_regs_tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot, dc_inject_level;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, custom_pattern_active;
  logic [1:0]  s_axi_bresp, s_axi_rresp, statistics_channel_select;
  logic [11:0] test_word;
  adc_diag_pkg::sense_s     sense_in;
  adc_diag_pkg::diag_ctrl_s diag_ctrl;
  int          bad_count = 0;
  int          samples_checked = 0;

  adc_diag_config_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense_in, .diag_ctrl,
    .dc_inject_level, .statistics_channel_select, .test_word, .custom_pattern_active, .irq);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic complete_run;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Handshakes are judged on values settled at the falling edge before each rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb, bv;
    tb = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      bv = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= bv && !tb;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr, rv;
    tr = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      rv = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      s_axi_rready <= rv && !tr;
    end
  endtask

  task automatic wchk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    wr(a, {24'h0, d}, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic irq_is(input logic e);
    repeat (6) @(negedge aclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge aclk);
  endtask

  task automatic check_reset_values;
    logic [7:0] regs [6] = '{8'h38, 8'h3c, 8'h40, 8'h44, 8'h4c, 8'h50};
    foreach (regs[i]) rchk(regs[i], 32'h0, 2'h0);
    irq_is(1'b0);
  endtask

  task automatic check_test_word;
    wchk(8'h38, 8'ha5, 2'h0);
    wchk(8'h3c, 8'hff, 2'h0);
    rchk(8'h38, 32'ha5, 2'h0);
    rchk(8'h3c, 32'hf0, 2'h0);
    wchk(8'h28, 8'h55, 2'h0);
    wchk(8'h2c, 8'h50, 2'h0);
    @(negedge aclk);
    chk("test_word", 32'ha5f, {20'h0, test_word});
    chk("pattern", 32'h7, {28'h0, custom_pattern_active});
    @(posedge aclk);
    wchk(8'h28, 8'h05, 2'h0);
    wchk(8'h2c, 8'h45, 2'h0);
    @(negedge aclk);
    chk("pattern", 32'ha, {28'h0, custom_pattern_active});
    @(posedge aclk);
  endtask

  task automatic check_diag_control;
    wchk(8'h4c, 8'hff, 2'h0);
    rchk(8'h4c, 32'h73, 2'h0);
    chk("diag_ctrl", 32'h3e, {26'h0, diag_ctrl});
    for (int c = 0; c < 4; c++) begin
      wchk(8'h4c, 8'h70 | 8'(c), 2'h0);
      rchk(8'h4c, 32'h70 | 32'(c), 2'h0);
    end
    wchk(8'h4c, 8'h00, 2'h0);
    wchk(8'h80, 8'h37, 2'h0);
    chk("level_sel", 32'h0, {27'h0, dc_inject_level, statistics_channel_select});
    wchk(8'h4c, 8'h30, 2'h0);
    wchk(8'h80, 8'h37, 2'h0);
    chk("level_sel", 32'h1f, {27'h0, dc_inject_level, statistics_channel_select});
  endtask

  task automatic check_sense_and_irq;
    sense_in <= '{4'ha, 1'b1, 9'h1b5};
    wchk(8'h4c, 8'h40, 2'h0);
    rchk(8'h40, 32'hc0, 2'h0);
    rchk(8'h44, 32'h0, 2'h0);
    wchk(8'h50, 8'hff, 2'h0);
    rchk(8'h50, 32'h04, 2'h0);
    rchk(8'h40, 32'ha6, 2'h0);
    rchk(8'h44, 32'h30, 2'h0);
    wchk(8'hc4, 8'h01, 2'h0);
    sense_in.clk_present <= 1'b0;
    irq_is(1'b1);
    rchk(8'h40, 32'hb6, 2'h0);
    rchk(8'hc0, 32'h01, 2'h0);
    wchk(8'hc4, 8'h00, 2'h0);
    irq_is(1'b0);
    wchk(8'hc4, 8'h01, 2'h0);
    irq_is(1'b1);
    sense_in.clk_present <= 1'b1;
    wchk(8'hc0, 8'h01, 2'h0);
    irq_is(1'b0);
    sense_in.ref_health <= 4'h0;
    irq_is(1'b0);
    rchk(8'hc0, 32'h02, 2'h0);
    wchk(8'h48, 8'hff, 2'h2);
    rchk(8'h48, 32'h0, 2'h2);
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
     s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    sense_in = '{4'h0, 1'b1, 9'h0};
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_reset_values();
    check_test_word();
    check_diag_control();
    check_sense_and_irq();
    complete_run();
  end

  initial begin
    repeat (4000) @(posedge aclk);
    bad_count++;
    $display("[FAIL] run_time expected done seen hang");
    complete_run();
  end
endmodule
